// *** core/btc_regs.vh ***
// What this block does
// - Once memory is full and capture goes on, newest record overwrites oldest.
// - Wrap mode never stops on full; acquisition ends when program halts.
// - Stop-on-full mode stops capturing once memory is filled, no overwrite.
// - Delayed-stop mode counts configured bus cycles after trace point, then stops.
// - Delayed-stop count may reach the full trace memory capacity.
// - Repeat-until-halt stores 512-cycle window per trace point, re-arms, runs on.
// - Repeat-until-full stores 512-cycle windows until memory has no room.
// - Delay setting acts only in delayed-stop mode; window modes ignore it.
// - Wrap, stop-on-full, delayed-stop modes offer capture or exclude filtering.
// - Step execution records in wrap mode only when enabled; stop-on-full and delayed-stop drop it; window modes always store it.
// - Debugger memory access seizes target bus and pauses the program.
// - Each record holds takeover flag; 0 means bus held while program ran.
// - When enabled, record holds external trigger level, 1 high, 0 low.
// - Event-number tag option, the default tag type, tags each record.
// - Timestamp resets at each program start; records carry elapsed time.
// - Timestamp range ends at 3h03m15s; values after overflow unreliable.
// - Task-identifier option tags records with current task when RTOS runs.
// - Trace memory holds up to four mega records.
// - Window is trace point cycle, 255 before and 256 after.
// - Delay selectable as 0, 1, 2, 3 or 4 mega cycles, default 0.
`ifndef BTC_REGS_VH
`define BTC_REGS_VH

// ----------------------------------------------------------------
// Register indexes on the host port
// ----------------------------------------------------------------
`define BTC_REG_CTRL 4'h0
`define BTC_REG_STATUS 4'h1
`define BTC_REG_WPTR 4'h2
`define BTC_REG_RIDX 4'h3
`define BTC_REG_REC0 4'h4
`define BTC_REG_REC1 4'h5
`define BTC_REG_REC2 4'h6
`define BTC_REG_TSNOW 4'h7

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define BTC_CTRL_MODE 2:0
`define BTC_CTRL_FEN 3
`define BTC_CTRL_FEXCL 4
`define BTC_CTRL_STEP 5
`define BTC_CTRL_EXT 6
`define BTC_CTRL_TAG 8:7
`define BTC_CTRL_DLY 11:9
`define BTC_CTRL_EN 12
`define BTC_CTRL_W 13
`define BTC_CTRL_RST 13'h0000

// ----------------------------------------------------------------
// Modes, tag types, delay limit
// ----------------------------------------------------------------
`define BTC_MODE_WRAP 3'h0
`define BTC_MODE_FULL 3'h1
`define BTC_MODE_DELAY 3'h2
`define BTC_MODE_REP_HALT 3'h3
`define BTC_MODE_REP_FULL 3'h4
`define BTC_TAG_EVENT 2'h0
`define BTC_TAG_TASK 2'h1
`define BTC_TAG_LINK 2'h2
`define BTC_DLY_MAX 3'h4

// ----------------------------------------------------------------
// Window shape: index 255 bounds both the pre ring and post count
// ----------------------------------------------------------------
`define BTC_WIN_LAST 8'hff
`define BTC_WIN_SHIFT 9

// ----------------------------------------------------------------
// Record layout
// ----------------------------------------------------------------
`define BTC_REC_ADDR 23:0
`define BTC_REC_DATA 39:24
`define BTC_REC_TS 78:40
`define BTC_REC_TAKE 79
`define BTC_REC_EXT 80
`define BTC_REC_TP 81
`define BTC_REC_TAG 89:82
`define BTC_REC_W 90

// ----------------------------------------------------------------
// Timestamp span: 3 h 03 min 15 s at the 50 MHz bus clock
// ----------------------------------------------------------------
`define BTC_TS_HOURS 3
`define BTC_TS_MINUTES 3
`define BTC_TS_SECONDS 15
`define BTC_CLK_HZ 50000000

`endif

// *** core/btc_sync2.v ***
`timescale 1ns/1ps
// Two-stage synchroniser for levels from outside the clock domain
module btc_sync2 #(
	parameter W = 1
) (
	input wire i_clk,
	input wire i_sys_rst,
	input wire [W-1:0] i_async,
	output reg [W-1:0] o_sync
);
	reg [W-1:0] stage1;

	// First stage feeds only the second
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			stage1 <= {W{1'b0}};
			o_sync <= {W{1'b0}};
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule

// *** core/btc_trace_ctrl.v ***
`timescale 1ns/1ps
`include "btc_regs.vh"
// Bus trace acquisition controller
module btc_trace_ctrl #(
	parameter AW = 22,
	parameter MEGA = 1048576
) (
	input wire i_clk,
	input wire i_sys_rst,
	// Observed target bus
	input wire i_bus_valid,
	input wire [23:0] i_bus_addr,
	input wire [15:0] i_bus_data,
	input wire i_prog_running,
	input wire i_step_cycle,
	input wire i_trace_point,
	input wire i_filter_match,
	input wire [7:0] i_event_number_tag,
	input wire [7:0] i_task_identifier_tag,
	input wire i_rtos_active,
	input wire [7:0] i_event_link_target_tag,
	input wire i_external_trigger_level,
	// Debugger memory access
	input wire i_dbg_access,
	output reg o_bus_seize,
	output reg o_cpu_hold,
	// Host register port
	input wire [3:0] i_reg_addr,
	input wire [31:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire i_reg_rd,
	output reg [31:0] o_reg_rdata,
	output wire o_acq_active
);
	localparam DEPTH = 1 << AW;
	localparam SW = AW - `BTC_WIN_SHIFT;
	localparam [AW:0] MEGA_W = MEGA;
	localparam TS_SPAN = 64'd3600 * `BTC_TS_HOURS
		+ 64'd60 * `BTC_TS_MINUTES + `BTC_TS_SECONDS;
	localparam TS_W = $clog2(TS_SPAN * `BTC_CLK_HZ);
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_RUN = 2'd1;
	localparam [1:0] ST_POST = 2'd2;
	localparam [1:0] ST_DONE = 2'd3;

	// ------------------------------------------------------------
	// Storage and state
	// ------------------------------------------------------------
	reg [`BTC_REC_W-1:0] mem [0:DEPTH-1];
	reg [`BTC_CTRL_W-1:0] ctrl;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [AW-1:0] wr_ptr;
	reg [AW:0] count;
	reg wrapped;
	reg [SW-1:0] slot;
	reg [7:0] ring;
	reg [7:0] post_cnt;
	reg [AW:0] dly_cnt;
	reg [AW-1:0] rd_idx;
	reg [TS_W-1:0] ts;
	reg run_q;
	wire ext_sync;

	btc_sync2 #(
		.W(1)
	) u_ext_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_external_trigger_level),
		.o_sync(ext_sync)
	);

	// ------------------------------------------------------------
	// Decode of configuration
	// ------------------------------------------------------------
	wire [2:0] mode = ctrl[`BTC_CTRL_MODE];
	wire win_mode = (mode == `BTC_MODE_REP_HALT) ||
		(mode == `BTC_MODE_REP_FULL);
	wire prog_start = i_prog_running & ~run_q;
	wire prog_stop = ~i_prog_running & run_q;
	wire capturing = (state == ST_RUN) || (state == ST_POST);
	wire cyc = capturing & i_bus_valid;
	assign o_acq_active = capturing;

	wire filt_ok = ~ctrl[`BTC_CTRL_FEN] |
		(i_filter_match ^ ctrl[`BTC_CTRL_FEXCL]);
	// linear modes keep steps only in wrap mode when enabled
	wire step_ok = ~i_step_cycle |
		((mode == `BTC_MODE_WRAP) & ctrl[`BTC_CTRL_STEP]);
	wire lin_store = cyc & ~win_mode & filt_ok & step_ok;
	wire win_store = cyc & win_mode;
	wire in_post = (state == ST_POST);
	wire [7:0] win_idx = in_post ? post_cnt : ring;
	wire [AW-1:0] win_addr = {slot, in_post, win_idx};
	wire [AW-1:0] mem_addr = win_mode ? win_addr : wr_ptr;
	wire mem_we = lin_store | win_store;
	wire tp = cyc & i_trace_point;

	// delay choice clamped at four mega cycles
	wire [2:0] dly_sel = (ctrl[`BTC_CTRL_DLY] > `BTC_DLY_MAX) ?
		`BTC_DLY_MAX : ctrl[`BTC_CTRL_DLY];
	// full capacity delay fits the counter
	wire [AW:0] dly_load = dly_sel * MEGA_W;
	// stored delay field never exceeds four mega
	wire [2:0] dly_wr = (i_reg_wdata[`BTC_CTRL_DLY] > `BTC_DLY_MAX) ?
		`BTC_DLY_MAX : i_reg_wdata[`BTC_CTRL_DLY];
	wire last_slot = (slot == {SW{1'b1}});
	wire full_now = (count == DEPTH - 1);

	// ------------------------------------------------------------
	// Record assembly
	// ------------------------------------------------------------
	reg [7:0] tag;
	// event number is the reset default tag
	// task id only while the RTOS runs
	always @* begin
		case (ctrl[`BTC_CTRL_TAG])
			`BTC_TAG_EVENT: tag = i_event_number_tag;
			`BTC_TAG_TASK: tag = i_rtos_active ?
				i_task_identifier_tag : 8'h00;
			`BTC_TAG_LINK: tag = i_event_link_target_tag;
			default: tag = 8'h00;
		endcase
	end

	reg [`BTC_REC_W-1:0] rec;
	always @* begin
		rec = {`BTC_REC_W{1'b0}};
		rec[`BTC_REC_ADDR] = i_bus_addr;
		rec[`BTC_REC_DATA] = i_bus_data;
		rec[`BTC_REC_TS] = ts;
		// low while emulator holds bus during a run
		rec[`BTC_REC_TAKE] = ~(o_bus_seize & i_prog_running);
		rec[`BTC_REC_EXT] = ctrl[`BTC_CTRL_EXT] & ext_sync;
		rec[`BTC_REC_TP] = i_trace_point;
		rec[`BTC_REC_TAG] = tag;
	end

	// Memory write port
	always @(posedge i_clk) begin
		if (mem_we) begin
			mem[mem_addr] <= rec;
		end
	end

	// ------------------------------------------------------------
	// Timestamp counter
	// ------------------------------------------------------------
	// cleared on each program start
	// free wrap after the span ends
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			ts <= {TS_W{1'b0}};
			run_q <= 1'b0;
		end else begin
			run_q <= i_prog_running;
			if (prog_start) begin
				ts <= {TS_W{1'b0}};
			end else begin
				ts <= ts + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Debugger bus takeover
	// ------------------------------------------------------------
	// seize bus and pause program while access lasts
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_bus_seize <= 1'b0;
			o_cpu_hold <= 1'b0;
		end else begin
			o_bus_seize <= i_dbg_access;
			o_cpu_hold <= i_dbg_access & i_prog_running;
		end
	end

	// ------------------------------------------------------------
	// Acquisition state machine
	// ------------------------------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE, ST_DONE: begin
				if (prog_start & ctrl[`BTC_CTRL_EN]) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (prog_stop) begin
					next_state = ST_DONE;
				end else if (mode == `BTC_MODE_FULL) begin
					if (lin_store & full_now) begin
						next_state = ST_DONE;
					end
				end else if (mode == `BTC_MODE_DELAY) begin
					if (tp) begin
						next_state = (dly_sel == 3'h0) ?
							ST_DONE : ST_POST;
					end
				end else if (win_mode & tp) begin
					// pulse on the matching cycle opens window
					next_state = ST_POST;
				end
			end
			ST_POST: begin
				if (prog_stop) begin
					next_state = ST_DONE;
				end else if (mode == `BTC_MODE_DELAY) begin
					if (i_bus_valid && dly_cnt == 1) begin
						next_state = ST_DONE;
					end
				end else if (win_store &&
					post_cnt == `BTC_WIN_LAST) begin
					if (mode == `BTC_MODE_REP_FULL && last_slot) begin
						next_state = ST_DONE;
					end else begin
						next_state = ST_RUN;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Pointers and counters
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			state <= ST_IDLE;
			wr_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			wrapped <= 1'b0;
			slot <= {SW{1'b0}};
			ring <= 8'h00;
			post_cnt <= 8'h00;
			dly_cnt <= {(AW+1){1'b0}};
		end else begin
			state <= next_state;
			if ((state == ST_IDLE || state == ST_DONE) &&
				next_state == ST_RUN) begin
				wr_ptr <= {AW{1'b0}};
				count <= {(AW+1){1'b0}};
				wrapped <= 1'b0;
				slot <= {SW{1'b0}};
				ring <= 8'h00;
			end else begin
				// depth is the mega record memory
				if (lin_store) begin
					wr_ptr <= wr_ptr + 1'b1;
					if (count == DEPTH) begin
						wrapped <= 1'b1;
					end else begin
						count <= count + 1'b1;
					end
				end
				// 256-entry ring holds trace point and 255 before
				if (win_store & ~in_post) begin
					ring <= ring + 1'b1;
				end
				if (state == ST_RUN && next_state == ST_POST) begin
					post_cnt <= 8'h00;
					// delay loaded on every entry to post, window modes included
					dly_cnt <= dly_load;
				end else if (state == ST_POST) begin
					// 256 cycles follow the trace point
					if (win_store) begin
						post_cnt <= post_cnt + 1'b1;
					end
					if (i_bus_valid && dly_cnt != 0) begin
						dly_cnt <= dly_cnt - 1'b1;
					end
				end
				if (win_store && in_post &&
					post_cnt == `BTC_WIN_LAST) begin
					slot <= slot + 1'b1;
					ring <= 8'h00;
					if (last_slot) begin
						wrapped <= 1'b1;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Host register port
	// ------------------------------------------------------------
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl <= `BTC_CTRL_RST;
			rd_idx <= {AW{1'b0}};
		end else if (i_reg_wr) begin
			if (i_reg_addr == `BTC_REG_CTRL) begin
				ctrl <= i_reg_wdata[`BTC_CTRL_W-1:0];
				ctrl[`BTC_CTRL_DLY] <= dly_wr;
			end else if (i_reg_addr == `BTC_REG_RIDX) begin
				rd_idx <= i_reg_wdata[AW-1:0];
			end
		end
	end

	// Read data stands the cycle after the strobe
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_reg_rdata <= 32'h00000000;
		end else if (i_reg_rd) begin
			if (i_reg_addr == `BTC_REG_CTRL) begin
				o_reg_rdata <= {{(32-`BTC_CTRL_W){1'b0}}, ctrl};
			end else if (i_reg_addr == `BTC_REG_STATUS) begin
				o_reg_rdata <= {{(28-AW){1'b0}}, count,
					wrapped, state};
			end else if (i_reg_addr == `BTC_REG_WPTR) begin
				o_reg_rdata <= {{(31-AW){1'b0}}, win_mode,
					win_mode ? {slot, {`BTC_WIN_SHIFT{1'b0}}} :
					wr_ptr};
			end else if (i_reg_addr == `BTC_REG_RIDX) begin
				o_reg_rdata <= {{(32-AW){1'b0}}, rd_idx};
			end else if (i_reg_addr == `BTC_REG_REC0) begin
				o_reg_rdata <= mem[rd_idx][31:0];
			end else if (i_reg_addr == `BTC_REG_REC1) begin
				o_reg_rdata <= mem[rd_idx][63:32];
			end else if (i_reg_addr == `BTC_REG_REC2) begin
				o_reg_rdata <= {{(96-`BTC_REC_W){1'b0}},
					mem[rd_idx][`BTC_REC_W-1:64]};
			end else if (i_reg_addr == `BTC_REG_TSNOW) begin
				o_reg_rdata <= ts[31:0];
			end else begin
				o_reg_rdata <= 32'h00000000;
			end
		end
	end
endmodule

// *** test/btc_trace_ctrl_asserts.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the trace controller
// ----------------------------------------------------------------
module btc_trace_ctrl_asserts (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_prog_running,
	input wire i_dbg_access,
	input wire o_bus_seize,
	input wire o_cpu_hold,
	input wire [3:0] i_reg_addr,
	input wire [31:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [31:0] o_reg_rdata,
	input wire o_acq_active
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	property p_seize; i_dbg_access |=> o_bus_seize; endproperty
	a_seize: assert property (p_seize) else $error("seize missing");
	property p_free; !i_dbg_access |=> !o_bus_seize; endproperty
	a_free: assert property (p_free) else $error("seize stuck");
	property p_hold; i_dbg_access && i_prog_running |=> o_cpu_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("hold missing");
	property p_nohold; !i_prog_running |=> !o_cpu_hold; endproperty
	a_nohold: assert property (p_nohold) else $error("hold idle");
	property p_both; o_cpu_hold |-> o_bus_seize; endproperty
	a_both: assert property (p_both) else $error("hold alone");
	property p_halt; $fell(i_prog_running) |-> ##[1:3] !o_acq_active;
	endproperty
	a_halt: assert property (p_halt) else $error("no stop on halt");
	property p_idle; (!i_prog_running) [*4] |-> !o_acq_active; endproperty
	a_idle: assert property (p_idle) else $error("active halted");
	property p_clamp;
		(i_reg_wr && i_reg_addr == 4'h0 && i_reg_wdata[11:9] > 3'h4)
		##[1:2] (i_reg_rd && i_reg_addr == 4'h0)
		|=> o_reg_rdata[11:9] == 3'h4;
	endproperty
	a_clamp: assert property (p_clamp) else $error("delay unclamped");
endmodule
bind btc_trace_ctrl btc_trace_ctrl_asserts i_btc_trace_ctrl_asserts (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_prog_running(i_prog_running),
	.i_dbg_access(i_dbg_access), .o_bus_seize(o_bus_seize),
	.o_cpu_hold(o_cpu_hold), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .o_acq_active(o_acq_active)
);

// *** test/btc_tgt_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Target bus model: one cycle per clock while the program runs
// ----------------------------------------------------------------
module btc_tgt_model (
	input wire i_clk,
	input wire i_run,
	output reg o_valid = 1'b0,
	output reg [23:0] o_addr = 24'h000000,
	output reg [15:0] o_data = 16'h0000,
	output reg o_trace_point = 1'b0
);
	reg [15:0] cnt = 16'h0000;
	// Address is the cycle number since program start
	always @(posedge i_clk) begin
		cnt <= i_run ? cnt + 16'h0001 : 16'h0000;
		o_valid <= i_run;
		o_addr <= {8'h00, cnt};
		o_data <= i_run ? ~cnt : ~o_data; // Idle data toggles
		o_trace_point <= i_run && (cnt % 16'h0190 == 16'h012c);
	end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module tb;
	reg clk, rst, prog, dbg, external_trigger_level, rtos, wr_s, rd_s;
	reg [7:0] ttag, etag;
	reg [3:0] raddr;
	reg [31:0] wdata, s, w;
	reg [89:0] r0, r1;
	reg [2:0] d;
	integer err_count, checks_done, i, e;
	wire valid, tp, seize, hold, act;
	wire [23:0] addr;
	wire [15:0] data;
	wire [31:0] rdata;
	btc_tgt_model i_btc_tgt_model (.i_clk(clk), .i_run(prog),
		.o_valid(valid), .o_addr(addr), .o_data(data), .o_trace_point(tp));
	btc_trace_ctrl #(.AW(10), .MEGA(64)) i_btc_trace_ctrl (
		.i_clk(clk), .i_sys_rst(rst), .i_bus_valid(valid),
		.i_bus_addr(addr), .i_bus_data(data), .i_prog_running(prog),
		.i_step_cycle(1'b0), .i_trace_point(tp), .i_filter_match(addr[0]),
		.i_event_number_tag(etag), .i_task_identifier_tag(ttag),
		.i_rtos_active(rtos), .i_event_link_target_tag(8'h11),
		.i_external_trigger_level(external_trigger_level), .i_dbg_access(dbg),
		.o_bus_seize(seize), .o_cpu_hold(hold), .i_reg_addr(raddr),
		.i_reg_wdata(wdata), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
		.o_reg_rdata(rdata), .o_acq_active(act));
	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task chk(input string nm, input [63:0] seen, input [63:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("[FAIL] %0s exp %0h seen %0h", nm, exp, seen);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] v);
		begin
			@(posedge clk);
			wr_s <= 1'b1;
			raddr <= a;
			wdata <= v;
			@(posedge clk);
			wr_s <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, output [31:0] q);
		begin
			@(posedge clk);
			rd_s <= 1'b1;
			raddr <= a;
			@(posedge clk);
			rd_s <= 1'b0;
			#1 q = rdata;
		end
	endtask
	task rec(input [15:0] n, output [89:0] r);
		reg [31:0] a, b, c;
		begin
			wr(4'h3, {16'h0000, n});
			rd(4'h4, a);
			rd(4'h5, b);
			rd(4'h6, c);
			r = {c[25:0], b, a};
		end
	endtask
	// Configure, read back, start the program
	task go(input [31:0] cfg, input integer n);
		reg [31:0] q, x;
		begin
			wr(4'h0, cfg);
			rd(4'h0, q);
			x = cfg;
			if (cfg[11:9] > 3'h4) x[11:9] = 3'h4;
			chk("ctrl readback", q[12:0], x[12:0]);
			@(posedge clk);
			prog <= 1'b1;
			repeat (n) @(posedge clk);
		end
	endtask
	task stop;
		begin
			prog <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task close_out;
		begin
			$display("checks %0d mismatches %0d", checks_done, err_count);
			if (err_count == 0 && checks_done > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// Watchdog
	initial begin
		repeat (80000) @(posedge clk);
		err_count = err_count + 1;
		close_out;
	end
	// Test sequence
	initial begin
		err_count = 0;
		checks_done = 0;
		rst = 1'b1;
		{prog, dbg, external_trigger_level, rtos, wr_s, rd_s} = 6'h00;
		{ttag, etag, raddr, wdata} = 52'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(4'h0, s);
		chk("ctrl reset", s, 32'h0);
		rd(4'h8, s);
		chk("unmapped read", s, 32'h0);
		$display("defaults done");
		go(32'h00001001, 1200);
		rd(4'h1, s);
		chk("full state", s[2:0], 3'h3);
		chk("full count", s[13:3], 11'h400);
		chk("full idle", act, 1'b0);
		rec(16'h0000, r0);
		rec(16'h03ff, r1);
		chk("full span", r1[23:0] - r0[23:0], 24'h0003ff);
		stop;
		$display("stop on full done");
		go(32'h00001000, 1500);
		rd(4'h1, s);
		chk("wrap running", s[2:0], 3'h5);
		stop;
		rd(4'h1, s);
		chk("wrap halted", s[1:0], 2'h3);
		rd(4'h2, w);
		rec({6'h00, w[9:0]}, r0);
		rec({6'h00, w[9:0] - 10'h001}, r1);
		chk("wrap oldest", r1[23:0] - r0[23:0], 24'h0003ff);
		$display("wrap done");
		for (i = 0; i < 2; i = i + 1) begin
			go(32'h00001008 | (i << 4), 30);
			stop;
			rec(16'h0002, r0);
			rec(16'h0003, r1);
			chk("filter parity", r0[0], (i == 0));
			chk("filter step", r1[23:0] - r0[23:0], 24'h2);
		end
		$display("filter done");
		for (i = 0; i < 3; i = i + 1) begin
			d = (i == 0) ? 3'h0 : (i == 1) ? 3'h2 : 3'h7;
			e = (i == 2) ? 256 : d * 64;
			go(32'h00001002 | (d << 9), 700);
			rd(4'h1, s);
			chk("delay state", s[1:0], 2'h3);
			rec(s[18:3] - 16'h0001, r1);
			chk("delay last", r1[23:0], 300 + e);
			stop;
		end
		$display("delayed stop done");
		for (i = 3; i < 5; i = i + 1) begin
			go(32'h00001600 | i, 1450);
			rd(4'h1, s);
			chk("window state", s[1:0], (i == 3) ? 2'h1 : 2'h3);
			rec(16'h0100, r0);
			chk("window first", r0[23:0], (i == 3) ? 1101 : 301);
			rec(16'h03ff, r1);
			chk("window last", r1[23:0], 956);
			stop;
		end
		$display("window modes done");
		for (i = 0; i < 2; i = i + 1) begin
			dbg <= (i == 0);
			external_trigger_level <= (i == 0);
			rtos <= 1'b1;
			ttag <= 8'h5a;
			etag <= 8'h33;
			go(32'h00001040 | ((i == 0) << 7), 40);
			stop;
			dbg <= 1'b0;
			rec(16'h000a, r1);
			chk("takeover", r1[79], (i == 1));
			chk("ext level", r1[80], (i == 0));
			chk("tag", r1[89:82], (i == 0) ? 8'h5a : 8'h33);
			rec(16'h0000, r0);
			chk("ts start", r0[78:40] < 39'h8, 1'b1);
		end
		$display("record fields done");
		close_out;
	end
endmodule
